// file: hw/dtc_core.sv
/*
 * dual 8/16-bit timer/counter core: first timer with four modes, second
 * timer count bytes, register port, overflow flags and interrupt.
 * register map: the four count bytes, a control byte (mode, source, gate
 * and both run bits), a status byte of sticky overflow flags cleared by
 * writing one, and an interrupt mask of the same layout.
 * assumes count and gate pins are synchronous to clk; the second timer's
 * own counting modes live elsewhere, only its bytes and its run/flag
 * bits used by the split mode are kept here.
 * limitation: a 16-bit count is two separate bytes with no read latch, so
 * software reading it while running must read high, low, then high again.
 */
// Summary of operation
// - source select 0: first timer advances once every two system clocks.
// - source select 1: first timer advances on each falling edge of count pin.
// - mode 00: high byte counts, low byte 5-bit prescaler; mode 01: 16-bit.
// - mode 10: low byte counts, reloaded from high byte on overflow.
// - mode 11: low byte is independent 8-bit counter under first timer controls.
// - mode 11: high byte runs on second run bit, sets second overflow flag.
// - first timer low and high bytes read/write, reset to 00h.
// - second timer low and high bytes read/write, reset to 00h.
// - first timer advances only while its run bit is 1.
// - gating bit 1 also requires the gate pin high to count.
// - first overflow flag set by hardware, cleared on interrupt vectoring.
`timescale 1ns/1ps
`include "dtc_defs.svh"
module dtc_core
    import dtc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       timer_a_count_pin,
    input  wire logic       timer_a_gate_pin,
    input  wire logic       timer_a_vector_ack,
    input  wire logic       timer_b_vector_ack,
    output logic            irq
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] timer_a_count_low;
    logic [7:0] timer_a_count_high;
    logic [7:0] timer_b_count_low;
    logic [7:0] timer_b_count_high;
    logic [7:0] ctrl;
    logic [1:0] status;
    logic [1:0] mask;
    logic       pin_prev;
    logic       tick2;

    dtc_tick_div #(
        .DIV (`DTC_TICK_DIV)
    ) u_div (
        .clk  (clk),
        .srst (srst),
        .tick (tick2)
    );

    // ----------------------------------------------------------------
    // control decode
    // ----------------------------------------------------------------
    wire dtc_mode_e timer_a_mode_field =
        dtc_mode_e'(ctrl[`DTC_CTRL_MODE_HI:`DTC_CTRL_MODE_LO]);
    wire timer_a_source_select = ctrl[`DTC_CTRL_SRC];
    wire timer_a_gating_bit    = ctrl[`DTC_CTRL_GATE];
    wire timer_a_run_bit       = ctrl[`DTC_CTRL_RUN_A];
    wire timer_b_run_bit       = ctrl[`DTC_CTRL_RUN_B];
    wire timer_a_overflow_flag = status[`DTC_ST_OVF_A];
    wire timer_b_overflow_flag = status[`DTC_ST_OVF_B];

    // ----------------------------------------------------------------
    // count enables
    // ----------------------------------------------------------------
    // the divider runs free, so the first timed step after a start lands within two clocks
    // count pin is taken as synchronous, so one register is enough to see a fall
    wire pin_fall = pin_prev & ~timer_a_count_pin;
    wire src_evt  = timer_a_source_select ? pin_fall : tick2;
    wire enable_a = timer_a_run_bit
                  & (~timer_a_gating_bit | timer_a_gate_pin);
    wire step_a   = src_evt & enable_a;
    // split high byte keeps timer mode only; its own gate/source belong to timer b
    wire step_h   = tick2 & timer_b_run_bit;

    // ----------------------------------------------------------------
    // register port decode
    // ----------------------------------------------------------------
    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] off);
        return reg_wr && (a == off);
    endfunction

    wire wr_al   = wr_hit(reg_addr, `DTC_ADDR_A_LOW);
    wire wr_ah   = wr_hit(reg_addr, `DTC_ADDR_A_HIGH);
    wire wr_bl   = wr_hit(reg_addr, `DTC_ADDR_B_LOW);
    wire wr_bh   = wr_hit(reg_addr, `DTC_ADDR_B_HIGH);
    wire wr_ctl  = wr_hit(reg_addr, `DTC_ADDR_CTRL);
    wire wr_st   = wr_hit(reg_addr, `DTC_ADDR_STATUS);
    wire wr_mask = wr_hit(reg_addr, `DTC_ADDR_MASK);

    // ----------------------------------------------------------------
    // counting per mode
    // ----------------------------------------------------------------
    // one incrementer per byte; bit 8 is the carry that marks an all-ones wrap
    function automatic logic [8:0] inc8(input logic [7:0] v);
        return {1'b0, v} + 9'h001;
    endfunction

    wire [8:0] low_inc    = inc8(timer_a_count_low);
    wire [8:0] high_inc   = inc8(timer_a_count_high);
    wire       low_carry  = low_inc[8];
    wire       high_carry = high_inc[8];

    // mode 00: only the low five bits prescale, the top three bits hold
    wire       presc_wrap = (timer_a_count_low[4:0] == `DTC_PRESC_MAX);
    wire [7:0] presc_low  = presc_wrap ? {timer_a_count_low[7:5], 5'h00}
                                       : low_inc[7:0];
    wire [7:0] presc_high = presc_wrap ? high_inc[7:0] : timer_a_count_high;
    wire       presc_ovf  = presc_wrap & high_carry;

    // mode 01: the low byte carries into the high byte
    wire [7:0] wide_high  = low_carry ? high_inc[7:0] : timer_a_count_high;
    wire       wide_ovf   = low_carry & high_carry;

    // mode 10: the wrap takes the high byte in place of zero
    wire [7:0] reload_low = low_carry ? timer_a_count_high : low_inc[7:0];

    logic [7:0] next_low;
    logic [7:0] next_high;
    logic       ovf_a;
    logic       ovf_b;

    always_comb begin
        next_low  = timer_a_count_low;
        next_high = timer_a_count_high;
        ovf_a     = 1'b0;
        ovf_b     = 1'b0;
        case (timer_a_mode_field)
            DTC_MODE_PRESC: begin
                if (step_a) begin
                    next_low  = presc_low;
                    next_high = presc_high;
                    ovf_a     = presc_ovf;
                end
            end
            DTC_MODE_16BIT: begin
                if (step_a) begin
                    next_low  = low_inc[7:0];
                    next_high = wide_high;
                    ovf_a     = wide_ovf;
                end
            end
            DTC_MODE_RELOAD: begin
                if (step_a) begin
                    next_low = reload_low;
                    ovf_a    = low_carry;
                end
            end
            DTC_MODE_SPLIT: begin
                if (step_a) begin
                    next_low = low_inc[7:0];
                    ovf_a    = low_carry;
                end
                if (step_h) begin
                    next_high = high_inc[7:0];
                    ovf_b     = high_carry;
                end
            end
            default: begin
                next_low  = timer_a_count_low;
                next_high = timer_a_count_high;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // flags: hardware set wins over vectoring or software clear
    // ----------------------------------------------------------------
    wire  [1:0] set_flags  = {ovf_b, ovf_a};
    wire  [1:0] ack_flags  = {timer_b_vector_ack, timer_a_vector_ack};
    wire  [1:0] wclr_flags = wr_st ? reg_wdata[1:0] : 2'h0;
    wire  [1:0] clr_flags  = ack_flags | wclr_flags;
    wire  [1:0] next_status;

    generate
        for (genvar f = 0; f < 2; f++) begin : g_flag
            // an overflow in the clearing cycle keeps its flag
            assign next_status[f] = set_flags[f] | (status[f] & ~clr_flags[f]);
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (srst) begin
            status <= `DTC_RST_FLAGS;
        end else begin
            status <= next_status;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // a software write to a count byte overrides that cycle's step
    always_ff @(posedge clk) begin
        if (srst) begin
            timer_a_count_low <= `DTC_RST_BYTE;
        end else begin
            timer_a_count_low <= wr_al ? reg_wdata : next_low;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            timer_a_count_high <= `DTC_RST_BYTE;
        end else begin
            timer_a_count_high <= wr_ah ? reg_wdata : next_high;
        end
    end

    // second timer bytes are plain storage here
    always_ff @(posedge clk) begin
        if (srst) begin
            timer_b_count_low <= `DTC_RST_BYTE;
        end else if (wr_bl) begin
            timer_b_count_low <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            timer_b_count_high <= `DTC_RST_BYTE;
        end else if (wr_bh) begin
            timer_b_count_high <= reg_wdata;
        end
    end

    // the second run bit lives here too; it only feeds the split high byte
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl <= `DTC_RST_BYTE;
        end else if (wr_ctl) begin
            ctrl <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mask <= `DTC_RST_FLAGS;
        end else if (wr_mask) begin
            mask <= reg_wdata[1:0];
        end
    end

    // reset to the idle high level; a pin held low at release shows one fall, not counted as the run bit is still 0
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_prev <= 1'b1;
        end else begin
            pin_prev <= timer_a_count_pin;
        end
    end

    // ----------------------------------------------------------------
    // read port and interrupt
    // ----------------------------------------------------------------
    // reads have no side effect; only a write of one or vectoring clears a flag
    wire  [7:0] status_rd = {6'h00, timer_b_overflow_flag, timer_a_overflow_flag};
    wire  [7:0] mask_rd   = {6'h00, mask};
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr)
            `DTC_ADDR_A_LOW:  rd_mux = timer_a_count_low;
            `DTC_ADDR_A_HIGH: rd_mux = timer_a_count_high;
            `DTC_ADDR_B_LOW:  rd_mux = timer_b_count_low;
            `DTC_ADDR_B_HIGH: rd_mux = timer_b_count_high;
            `DTC_ADDR_CTRL:   rd_mux = ctrl;
            `DTC_ADDR_STATUS: rd_mux = status_rd;
            `DTC_ADDR_MASK:   rd_mux = mask_rd;
            default:          rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // built from the next flags so the interrupt rises on the edge that sets the flag
    wire next_irq = |(next_status & mask);
    always_ff @(posedge clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end
endmodule

// file: hw/dtc_tick_div.sv
/*
 * divider giving a one-cycle enable every DIV clocks.
 * assumes a single clock with synchronous active-high reset.
 */
`timescale 1ns/1ps
`include "dtc_defs.svh"
module dtc_tick_div
    import dtc_pkg::*;
#(
    parameter int DIV = `DTC_TICK_DIV
) (
    input  wire logic clk,
    input  wire logic srst,
    output logic      tick
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt;
    wire           at_last = (cnt == LAST);

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else begin
            cnt  <= at_last ? '0 : cnt + CW'(1);
            tick <= at_last;
        end
    end
endmodule

// file: pkg/dtc_defs.svh
/*
 * constants of the dual timer/counter core: register offsets, field
 * positions, reset values and timing counts.
 * assumes it is included by bare name from design files.
 */
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DTC_ADDR_A_LOW   8'h8A
`define DTC_ADDR_B_LOW   8'h8B
`define DTC_ADDR_A_HIGH  8'h8C
`define DTC_ADDR_B_HIGH  8'h8D
`define DTC_ADDR_CTRL    8'hA0
`define DTC_ADDR_STATUS  8'hA1
`define DTC_ADDR_MASK    8'hA2

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define DTC_CTRL_MODE_LO 0
`define DTC_CTRL_MODE_HI 1
`define DTC_CTRL_SRC     2
`define DTC_CTRL_GATE    3
`define DTC_CTRL_RUN_A   4
`define DTC_CTRL_RUN_B   6

// ----------------------------------------------------------------
// status / mask fields
// ----------------------------------------------------------------
`define DTC_ST_OVF_A     0
`define DTC_ST_OVF_B     1

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define DTC_RST_BYTE     8'h00
`define DTC_RST_FLAGS    2'h0
`define DTC_TICK_DIV     2
`define DTC_PRESC_MAX    5'h1F

`endif

// file: pkg/dtc_pkg.sv
/*
 * types of the dual timer/counter core.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package dtc_pkg;
    typedef enum logic [1:0] {
        DTC_MODE_PRESC  = 2'b00,
        DTC_MODE_16BIT  = 2'b01,
        DTC_MODE_RELOAD = 2'b10,
        DTC_MODE_SPLIT  = 2'b11
    } dtc_mode_e;
endpackage

// file: verification/dtc_core_asserts.sv
/* port checker of dtc_core: read slots and interrupt behaviour.
   assumes a bind from the bench top, one clock, sync reset. */
`timescale 1ns/1ps
module dtc_core_asserts
    import dtc_pkg::*;
(
    input wire logic       clk,
    input wire logic       srst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       timer_a_vector_ack,
    input wire logic       irq
);
    // ------------------------------------------------
    // shadow of control and mask writes
    // ------------------------------------------------
    logic [7:0] ctrl_q;
    logic [7:0] mask_q;
    logic       was_off;
    wire        off_now = !ctrl_q[4] && !ctrl_q[6];
    // off for two cycles: no step can still be in flight
    wire        off = off_now && was_off;
    wire        hit = (reg_addr >= 8'h8A && reg_addr <= 8'h8D) ||
                      (reg_addr >= 8'hA0 && reg_addr <= 8'hA2);
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_q  <= 8'h00;
            mask_q  <= 8'h00;
            was_off <= 1'b1;
        end else begin
            was_off <= off_now;
            if (reg_wr && reg_addr == 8'hA0) ctrl_q <= reg_wdata;
            if (reg_wr && reg_addr == 8'hA2) mask_q <= reg_wdata;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // ------------------------------------------------
    // properties
    // ------------------------------------------------
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    a_unmapped_zero: assert property (reg_rd && !hit |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_a_low_rw: assert property (reg_wr && reg_addr == 8'h8A && off ##1
        reg_rd && reg_addr == 8'h8A |=> reg_rdata == $past(reg_wdata, 2))
        else $error("low byte readback");
    a_b_bytes_rw: assert property (reg_wr && (reg_addr == 8'h8B || reg_addr == 8'h8D)
        ##1 reg_rd && reg_addr == $past(reg_addr) |=> reg_rdata == $past(reg_wdata, 2))
        else $error("second timer byte readback");
    a_irq_masked: assert property (mask_q[1:0] == 2'b00 && !reg_wr |=> !irq)
        else $error("irq with mask clear");
    a_ack_clears: assert property (off && mask_q == 8'h01 && timer_a_vector_ack
        && !reg_wr |=> !irq)
        else $error("ack did not drop irq");
    a_wclr_status: assert property (off && mask_q[7:2] == 6'h00 && reg_wr
        && reg_addr == 8'hA1 && reg_wdata == 8'h03 |=> !irq)
        else $error("write one did not clear");
    a_stop_no_irq: assert property (off && !reg_wr && !$past(reg_wr) |=> !$rose(irq))
        else $error("irq rose while stopped");
endmodule

// file: verification/dtc_core_tb.sv
/* self-checking bench of dtc_core: register tasks and timer scenarios.
   assumes the checker and the pin model are compiled before it. */
`timescale 1ns/1ps
module dtc_core_tb
    import dtc_pkg::*;
();
    logic       clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic       timer_a_vector_ack = 1'b0, timer_b_vector_ack = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    wire  [7:0] reg_rdata;
    wire        irq, cnt_pin, gate_pin;
    int         fails = 0, compares = 0, cycles = 0;
    always #20 clk = ~clk;
    dtc_core u_dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .timer_a_count_pin(cnt_pin), .timer_a_gate_pin(gate_pin),
        .timer_a_vector_ack(timer_a_vector_ack),
        .timer_b_vector_ack(timer_b_vector_ack), .irq(irq));
    dtc_pin_model u_pins (.clk(clk), .timer_a_count_pin(cnt_pin),
        .timer_a_gate_pin(gate_pin));
    // ------------------------------------------------
    // bus tasks
    // ------------------------------------------------
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, r, input logic [7:0] a, d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= w;
        reg_rd    <= r;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, d);
        bus(1'b1, 1'b0, a, d);
        bus(1'b0, 1'b0, a, d);
    endtask
    task automatic rd(input logic [7:0] a, m, e);
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, a, 8'h00);
        chk(reg_rdata & m, e);
    endtask
    task automatic wrd(input logic [7:0] a, d);
        bus(1'b1, 1'b0, a, d);
        rd(a, 8'hFF, d);
    endtask
    // run until irq, stop, expect the masked flag alone
    task automatic ovf(input logic [7:0] lo, hi, m, c);
        wr(8'h8A, lo);
        wr(8'h8C, hi);
        wr(8'hA2, m);
        wr(8'hA0, c);
        repeat (600) if (irq !== 1'b1) @(posedge clk);
        chk({7'h00, irq}, 8'h01);
        wr(8'hA0, 8'h00);
        rd(8'hA1, 8'hFF, m);
    endtask
    task automatic ack(input logic b);
        if (b) timer_b_vector_ack <= 1'b1;
        else timer_a_vector_ack <= 1'b1;
        @(posedge clk);
        timer_a_vector_ack <= 1'b0;
        timer_b_vector_ack <= 1'b0;
        @(posedge clk);
        chk({7'h00, irq}, 8'h00);
        rd(8'hA1, 8'hFF, 8'h00);
    endtask
    task automatic finish_test();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            finish_test();
        end
    end
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 4; i++) rd(8'h8A + 8'(i), 8'hFF, 8'h00);
        wrd(8'h8B, 8'hA5);
        wrd(8'h8D, 8'h5A);
        wrd(8'h8A, 8'h3C);
        wrd(8'h8C, 8'hC3);
        rd(8'h80, 8'hFF, 8'h00);
        wr(8'h8A, 8'h00);
        wr(8'hA0, 8'h11);
        // 22 clocks of run give 11 steps
        repeat (20) @(posedge clk);
        wr(8'hA0, 8'h00);
        rd(8'h8A, 8'hFE, 8'h0A);
        wr(8'h8A, 8'hFF);
        wr(8'h8C, 8'h07);
        wr(8'hA0, 8'h10);
        repeat (6) @(posedge clk);
        wr(8'hA0, 8'h00);
        rd(8'h8C, 8'hFF, 8'h08);
        rd(8'h8A, 8'hE0, 8'hE0);
        ovf(8'hFE, 8'hFF, 8'h01, 8'h11);
        rd(8'h8A, 8'hFE, 8'h00);
        rd(8'h8C, 8'hFF, 8'h00);
        ack(1'b0);
        ovf(8'hFE, 8'hF0, 8'h01, 8'h12);
        rd(8'h8A, 8'hFE, 8'hF0);
        rd(8'h8C, 8'hFF, 8'hF0);
        wr(8'hA1, 8'h03);
        rd(8'hA1, 8'hFF, 8'h00);
        ovf(8'h55, 8'hFF, 8'h02, 8'h43);
        rd(8'h8A, 8'hFF, 8'h55);
        rd(8'h8C, 8'hFE, 8'h00);
        ack(1'b1);
        ovf(8'hFE, 8'h00, 8'h01, 8'h13);
        rd(8'h8C, 8'hFF, 8'h00);
        wr(8'h8A, 8'h00);
        wr(8'hA0, 8'h1D);
        u_pins.fall(3);
        rd(8'h8A, 8'hFF, 8'h00);
        u_pins.gate(1'b1);
        u_pins.fall(3);
        rd(8'h8A, 8'hFF, 8'h03);
        wr(8'hA0, 8'h0D);
        u_pins.fall(2);
        rd(8'h8A, 8'hFF, 8'h03);
        finish_test();
    end
endmodule
bind dtc_core dtc_core_asserts u_chk (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer_a_vector_ack(timer_a_vector_ack), .irq(irq));

// file: verification/dtc_pin_model.sv
/* pin model: count input (idle high, pulled up) and gate input.
   assumes its tasks are called just after a rising clock edge. */
`timescale 1ns/1ps
module dtc_pin_model
    import dtc_pkg::*;
(
    input  wire logic clk,
    output logic      timer_a_count_pin,
    output logic      timer_a_gate_pin
);
    initial begin
        timer_a_count_pin = 1'b1;
        timer_a_gate_pin  = 1'b0;
    end
    // each low is held two clocks so a synchronous sampler sees it
    task automatic fall(input int n);
        repeat (n) begin
            timer_a_count_pin <= 1'b0;
            repeat (2) @(posedge clk);
            timer_a_count_pin <= 1'b1;
            repeat (2) @(posedge clk);
        end
    endtask
    task automatic gate(input logic lvl);
        timer_a_gate_pin <= lvl;
        @(posedge clk);
    endtask
endmodule
